// [hsch2_channel2_monitor.sv]
// Checker for the channel 2 register bank, bound to the top module's ports.
`include "hsch2_defines.vh"
module hsch2_channel2_monitor #(
  parameter int RETRY_TIME_US = 1,
  parameter int CLK_MHZ       = 20
) (
  input logic        clk_i,
  input logic        srst_i,
  input logic [5:0]  reg_addr_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [15:0] reg_wdata_i,
  input logic [15:0] reg_rdata_o,
  input logic        switch_on_i,
  input logic        switch_state_write_i,
  input logic        shutdown_evt_i,
  input logic        thermal_hysteresis_i,
  input logic        offstate_comp_i,
  input logic        current_done_i,
  input logic [9:0]  current_data_i,
  input logic        current_scale_i,
  input logic        channel_enable_o,
  input logic        pulldown_en_o,
  input logic        pullup_en_o,
  input logic        offstate_openload_flag_o,
  input logic        short_to_supply_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Slack after the retry count, for sync and output registers.
  localparam int RMAX = RETRY_TIME_US * CLK_MHZ + 10;
  logic       latch_q;  // Latch-off choice as last written.
  logic [1:0] det_q;    // Detection mode as last written.
  logic       held_q;   // A latched shutdown still waits for a switch word write.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Shadow the config fields, since the checker cannot see the register.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      latch_q <= 1'b0;
      det_q   <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == `HSCH2_CONFIG_OFS) begin
      latch_q <= reg_wdata_i[`HSCH2_LATCH_BIT];
      det_q   <= reg_wdata_i[4:3];
    end
  end
  // Only a switch word write ends a latched shutdown.
  always_ff @(posedge clk_i) begin
    if (srst_i || switch_state_write_i) held_q <= 1'b0;
    else if (shutdown_evt_i && latch_q) held_q <= 1'b1;
  end
  property p_shut;
    shutdown_evt_i |=> !channel_enable_o;
  endproperty
  a_shut: assert property (p_shut)
    else $error("Channel stayed on after a shutdown event");
  property p_latch;
    held_q |-> !channel_enable_o;
  endproperty
  a_latch: assert property (p_latch)
    else $error("Latched channel came back without a switch word write");
  property p_retry;
    (!latch_q && shutdown_evt_i && switch_on_i && thermal_hysteresis_i) |=>
      (!channel_enable_o)[*8] ##[1:RMAX] channel_enable_o;
  endproperty
  a_retry: assert property (p_retry)
    else $error("Auto retry did not restore the channel in time");
  property p_pull;
    ($stable(det_q) && !channel_enable_o)[*3] |->
      pullup_en_o == (det_q == 2'h2) && pulldown_en_o == (det_q == 2'h1);
  endproperty
  a_pull: assert property (p_pull)
    else $error("Pull enables do not match the detection mode");
  property p_ol;
    (det_q == 2'h2 && !channel_enable_o && offstate_comp_i)[*8] |-> offstate_openload_flag_o;
  endproperty
  a_ol: assert property (p_ol)
    else $error("Open-load flag not set in pull-up mode");
  property p_short;
    (det_q == 2'h1 && !channel_enable_o && $stable(offstate_comp_i))[*8] |->
      short_to_supply_flag_o == offstate_comp_i;
  endproperty
  a_short: assert property (p_short)
    else $error("Short flag does not follow the comparator in pulldown mode");
  property p_rsvd;
    logic [5:0] a;
    (reg_rd_i && reg_addr_i >= 6'h1A && reg_addr_i <= 6'h1C, a = reg_addr_i) |=>
      ((a == 6'h1A) ? reg_rdata_o[15:12] == 4'hF : reg_rdata_o[15:11] == 5'h1F);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("Reserved result bits did not read as ones");
  property p_conv;
    logic [9:0] d;
    logic       s;
    (current_done_i, d = current_data_i, s = current_scale_i) ##1
      (!current_done_i && !reg_rd_i) ##1
      (reg_rd_i && reg_addr_i == 6'h1A && !current_done_i) |=>
      reg_rdata_o[11:0] == {s, 1'b1, d};
  endproperty
  a_conv: assert property (p_conv)
    else $error("Current result word did not carry the new conversion");
endmodule // hsch2_channel2_monitor

bind hsch2_channel2_regs hsch2_channel2_monitor #(
  .RETRY_TIME_US(RETRY_TIME_US), .CLK_MHZ(CLK_MHZ)) mon_u (
  .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .switch_on_i(switch_on_i), .switch_state_write_i(switch_state_write_i),
  .shutdown_evt_i(shutdown_evt_i), .thermal_hysteresis_i(thermal_hysteresis_i),
  .offstate_comp_i(offstate_comp_i), .current_done_i(current_done_i),
  .current_data_i(current_data_i), .current_scale_i(current_scale_i),
  .channel_enable_o(channel_enable_o), .pulldown_en_o(pulldown_en_o),
  .pullup_en_o(pullup_en_o), .offstate_openload_flag_o(offstate_openload_flag_o),
  .short_to_supply_flag_o(short_to_supply_flag_o));

// [hsch2_channel2_regs.v]
// Channel 2 configuration word, shutdown latch logic and conversion result words.

// Offsets, reset values and field positions come from the shared header.
`include "hsch2_defines.vh"

// The parameters default to the device's retry time and the 20 MHz system clock.
module hsch2_channel2_regs #(
  parameter RETRY_TIME_US = `HSCH2_RETRY_TIME_US,  // Retry time after a shutdown, microseconds.
  parameter CLK_MHZ       = `HSCH2_CLK_MHZ         // Clock rate in MHz.
) (
  input  wire        clk_i,
  input  wire        srst_i,
  // Register port from the serial interface front end.
  input  wire [5:0]  reg_addr_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [15:0] reg_wdata_i,
  output reg  [15:0] reg_rdata_o,
  // Switch command and protection events.
  input  wire        switch_on_i,
  input  wire        switch_state_write_i,
  input  wire        shutdown_evt_i,
  input  wire        thermal_hysteresis_i,
  input  wire        fault_clear_i,
  // Off-state detection comparator, asynchronous pin.
  input  wire        offstate_comp_i,
  // Converter results.
  input  wire        current_done_i,
  input  wire [9:0]  current_data_i,
  input  wire        current_scale_i,
  input  wire        temperature_done_i,
  input  wire [9:0]  temperature_data_i,
  input  wire        voltage_done_i,
  input  wire [9:0]  voltage_data_i,
  // Controls toward the analog channel.
  output reg         channel_enable_o,
  output reg         pulldown_en_o,
  output reg         pullup_en_o,
  output reg         comparator_en_o,
  output reg  [1:0]  slew_rate_select_o,
  output reg         sense_scale_select_o,
  output reg         offstate_openload_flag_o,
  output reg         short_to_supply_flag_o
);

  // Retry wait in cycles; a least time, so it rounds up (integer microseconds times MHz is exact).
  // The counter width limits the longest wait: a retry time beyond its range would wrap the
  // terminal count, so CW must grow with RETRY_TIME_US.
  localparam RETRY_CYCLES = RETRY_TIME_US * CLK_MHZ;
  localparam CW           = 24;                       // Counter width, enough for about 0.8 s at 20 MHz.
  localparam [31:0] RETRY_FULL = RETRY_CYCLES - 1;    // Terminal count at full integer width.
  localparam [CW-1:0] RETRY_LAST = RETRY_FULL[CW-1:0]; // Terminal count cut to the counter width.
  // Reset word of the configuration register; the slew and sense scale controls start from its fields.
  localparam [15:0] CONFIG_RST = `HSCH2_CONFIG_RST;

  // Registers of the bank; all but rdata_next, the combinational read mux output, run on the single clock.
  reg  [15:0]   config_reg;          // Channel 2 configuration word.
  reg  [9:0]    current_value_reg;   // Last current conversion.
  reg           current_scale_reg;   // Scaling applied to that conversion.
  reg           current_fresh_reg;   // New current conversion since last read.
  reg  [9:0]    temperature_value_reg; // Last temperature conversion.
  reg           temperature_fresh_reg; // New temperature conversion since last read.
  reg  [9:0]    voltage_value_reg;   // Last voltage conversion.
  reg           voltage_fresh_reg;   // New voltage conversion since last read.
  reg           comp_meta_reg;       // First synchroniser stage, read only by the second.
  reg           comp_sync_reg;       // Synchronised comparator level.
  reg           shutdown_reg;        // Channel held off after a protection event.
  reg  [CW-1:0] retry_cnt_reg;       // Cycles spent waiting since the shutdown.
  reg           retry_done_reg;      // Retry wait has elapsed.
  reg  [15:0]   rdata_next;          // Read data for the addressed word.

  // Field views of the configuration word and decoded strobes of the register port.
  wire [1:0] detect_mode = config_reg[`HSCH2_DETECT_MSB:`HSCH2_DETECT_LSB];  // Detect field.
  wire       latch_off_select = config_reg[`HSCH2_LATCH_BIT];              // Latch versus retry.
  wire       cfg_write = reg_wr_i && (reg_addr_i == `HSCH2_CONFIG_OFS);    // Config write strobe.
  wire       rd_current = reg_rd_i && (reg_addr_i == `HSCH2_CURRENT_OFS);  // Current word read.
  wire       rd_temperature = reg_rd_i && (reg_addr_i == `HSCH2_TEMPERATURE_OFS);
  wire       rd_voltage = reg_rd_i && (reg_addr_i == `HSCH2_VOLTAGE_OFS);

  // Result words as seen by the host; reserved bits read as ones.
  // The effective scale bit reports what the converter applied, not the current setting.
  wire [15:0] current_word = {`HSCH2_CUR_RSVD, current_scale_reg, current_fresh_reg,
                              current_value_reg};
  wire [15:0] temperature_word = {`HSCH2_TV_RSVD, temperature_fresh_reg,
                                  temperature_value_reg};
  wire [15:0] voltage_word = {`HSCH2_TV_RSVD, voltage_fresh_reg, voltage_value_reg};

  // Configuration word; the only writable register in this bank.
  // Every bit is plain storage, so fields that this block does not use still read back
  // what the host wrote.
  always @(posedge clk_i) begin
    if (srst_i) begin
      config_reg <= CONFIG_RST;  // Slew code 2, detection off, auto retry.
    end else if (cfg_write) begin
      config_reg <= reg_wdata_i;
    end
  end

  // Result registers. Writes never reach them, so a host write to a result offset is ignored.
  // A read clears the fresh flag, but a conversion landing in the same cycle sets it again:
  // losing a result the host has not yet seen would be worse than a duplicate report.
  // Values are kept across reads; only the fresh flags react to the host.
  // The three channels are independent, so conversions may land on them together.
  always @(posedge clk_i) begin
    if (srst_i) begin
      current_value_reg     <= 10'h000;
      current_scale_reg     <= 1'b0;
      current_fresh_reg     <= 1'b0;
      temperature_value_reg <= 10'h000;
      temperature_fresh_reg <= 1'b0;
      voltage_value_reg     <= 10'h000;
      voltage_fresh_reg     <= 1'b0;
    end else begin
      // Current channel.
      if (current_done_i) begin
        current_value_reg <= current_data_i;
        current_scale_reg <= current_scale_i;
        current_fresh_reg <= 1'b1;
      end else if (rd_current) begin
        current_fresh_reg <= 1'b0;
      end
      // Temperature channel.
      if (temperature_done_i) begin
        temperature_value_reg <= temperature_data_i;
        temperature_fresh_reg <= 1'b1;
      end else if (rd_temperature) begin
        temperature_fresh_reg <= 1'b0;
      end
      // Voltage channel.
      if (voltage_done_i) begin
        voltage_value_reg <= voltage_data_i;
        voltage_fresh_reg <= 1'b1;
      end else if (rd_voltage) begin
        voltage_fresh_reg <= 1'b0;
      end
    end
  end

  // Read multiplexer; an unmapped address returns zero.
  // The full address is decoded, so the mapped words have no aliases.
  always @* begin
    case (reg_addr_i)
      `HSCH2_CONFIG_OFS:      rdata_next = config_reg;
      `HSCH2_CURRENT_OFS:     rdata_next = current_word;
      `HSCH2_TEMPERATURE_OFS: rdata_next = temperature_word;
      `HSCH2_VOLTAGE_OFS:     rdata_next = voltage_word;
      default:                rdata_next = 16'h0000;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  // Capturing only on a read keeps the last answer steady while writes go on.
  always @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;  // Writes to result words change nothing here either.
    end
  end

  // Two-stage synchroniser for the asynchronous comparator pin.
  // Both stages reset low, the level of an output held down, so no fault is flagged
  // from stale pin history in the first cycles after reset.
  // The flag logic adds one more cycle, so a pin change shows about three cycles later.
  always @(posedge clk_i) begin
    if (srst_i) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= offstate_comp_i;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // Analog controls decoded from the configuration word, registered so outputs come from flops.
  // They lag the configuration word by one cycle; the flag logic below allows for that.
  always @(posedge clk_i) begin
    if (srst_i) begin
      pulldown_en_o        <= 1'b0;
      pullup_en_o          <= 1'b0;
      comparator_en_o      <= 1'b0;
      slew_rate_select_o   <= CONFIG_RST[`HSCH2_SLEW_MSB:`HSCH2_SLEW_LSB];
      sense_scale_select_o <= CONFIG_RST[`HSCH2_SCALE_BIT];
    end else begin
      // Detection only makes sense with the switch off, so the pulls follow the channel state.
      pulldown_en_o   <= !channel_enable_o && (detect_mode == `HSCH2_DETECT_PULLDOWN);
      pullup_en_o     <= !channel_enable_o && (detect_mode == `HSCH2_DETECT_PULLUP);
      comparator_en_o <= !channel_enable_o && (detect_mode != `HSCH2_DETECT_OFF);
      slew_rate_select_o   <= config_reg[`HSCH2_SLEW_MSB:`HSCH2_SLEW_LSB];
      sense_scale_select_o <= config_reg[`HSCH2_SCALE_BIT];
    end
  end

  // Off-state fault flags. The comparator is read only once its pull has been on for a cycle.
  // The open-load flag is sticky until the fault status is cleared; a new detection wins.
  // The short flag is not sticky: it tracks the comparator while the pulldown is on and
  // holds its last reading in every other mode, so the host may read it afterwards.
  always @(posedge clk_i) begin
    if (srst_i) begin
      offstate_openload_flag_o <= 1'b0;
      short_to_supply_flag_o   <= 1'b0;
    end else begin
      case (detect_mode)
        `HSCH2_DETECT_PULLUP: begin
          // Open load or short both pull the output high here.
          if (pullup_en_o && comp_sync_reg) begin
            offstate_openload_flag_o <= 1'b1;
          end else if (fault_clear_i) begin
            offstate_openload_flag_o <= 1'b0;
          end
        end
        `HSCH2_DETECT_PULLDOWN: begin
          // The host selects this mode to tell the two faults apart.
          if (pulldown_en_o) begin
            short_to_supply_flag_o <= comp_sync_reg;  // One means short, zero means open.
          end
          if (fault_clear_i) begin
            offstate_openload_flag_o <= 1'b0;
          end
        end
        default: begin
          // Disabled or external comparator mode: the open-load flag only clears, the short flag holds.
          // External comparator mode leaves the decision to the user's own switches.
          if (fault_clear_i) begin
            offstate_openload_flag_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // Retry counter: runs while the channel is shut down and the retry wait is unfinished.
  // It stops one past its terminal count rather than wrapping, since the hysteresis condition
  // may take far longer than the wait; a new shutdown event restarts it from zero.
  always @(posedge clk_i) begin
    if (srst_i) begin
      retry_cnt_reg  <= {CW{1'b0}};
      retry_done_reg <= 1'b0;
    end else if (!shutdown_reg || shutdown_evt_i) begin
      retry_cnt_reg  <= {CW{1'b0}};
      retry_done_reg <= 1'b0;
    end else if (!retry_done_reg) begin
      // Raise the done flag at the terminal value; the count steps once past it, then stops.
      if (retry_cnt_reg == RETRY_LAST) begin
        retry_done_reg <= 1'b1;
      end
      retry_cnt_reg <= retry_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Shutdown latch. A new event always wins over any release in the same cycle.
  // In latch mode the retry counter still runs but is ignored; only a switch word write
  // releases the channel then.
  always @(posedge clk_i) begin
    if (srst_i) begin
      shutdown_reg <= 1'b0;
    end else if (shutdown_evt_i) begin
      shutdown_reg <= 1'b1;
    end else if (shutdown_reg) begin
      // Which release applies depends on the latch-off choice.
      if (latch_off_select) begin
        if (switch_state_write_i) begin
          shutdown_reg <= 1'b0;   // Held off until the switch state is written again.
        end
      end else if (retry_done_reg && thermal_hysteresis_i) begin
        shutdown_reg <= 1'b0;     // Auto retry once both conditions hold.
      end
    end
  end

  // Channel drive: the commanded state unless a shutdown holds it off.
  // The event itself also masks the drive, so the channel drops on the edge that records
  // the event rather than one cycle later, when the latch has caught up.
  // After a release the channel returns only if the switch is still commanded on.
  always @(posedge clk_i) begin
    if (srst_i) begin
      channel_enable_o <= 1'b0;
    end else begin
      channel_enable_o <= switch_on_i && !shutdown_reg && !shutdown_evt_i;
    end
  end

endmodule // hsch2_channel2_regs

// [hsch2_defines.vh]
// Constants for the channel 2 configuration and conversion result register bank.
`ifndef HSCH2_DEFINES_VH
`define HSCH2_DEFINES_VH

// Register offsets on the internal register port.
`define HSCH2_CONFIG_OFS        6'h19
`define HSCH2_CURRENT_OFS       6'h1A
`define HSCH2_TEMPERATURE_OFS   6'h1B
`define HSCH2_VOLTAGE_OFS       6'h1C

// Reset values.
`define HSCH2_CONFIG_RST        16'h4002
`define HSCH2_CURRENT_RST       16'hF000
`define HSCH2_TEMPERATURE_RST   16'hF800
`define HSCH2_VOLTAGE_RST       16'hF800

// Configuration field positions.
`define HSCH2_SLEW_LSB          0
`define HSCH2_SLEW_MSB          1
`define HSCH2_LATCH_BIT         2
`define HSCH2_DETECT_LSB        3
`define HSCH2_DETECT_MSB        4
`define HSCH2_SCALE_BIT         10

// Off-state detection mode codes.
`define HSCH2_DETECT_OFF        2'h0
`define HSCH2_DETECT_PULLDOWN   2'h1
`define HSCH2_DETECT_PULLUP     2'h2
`define HSCH2_DETECT_COMPARATOR 2'h3

// Result word layout.
`define HSCH2_RESULT_MSB        9
`define HSCH2_FRESH_BIT         10
`define HSCH2_EFF_SCALE_BIT     11
`define HSCH2_CUR_RSVD          4'hF
`define HSCH2_TV_RSVD           5'h1F

// Retry time in microseconds and the clock rate in MHz.
`define HSCH2_RETRY_TIME_US     1000
`define HSCH2_CLK_MHZ           20

`endif

// [hsch2_host_model.sv]
// Host model that issues register reads and writes on the bank's register port.
module hsch2_host_model (
  input  logic        clk_i,
  input  logic [15:0] rdata_i,
  output logic [5:0]  addr_o,
  output logic        wr_o,
  output logic        rd_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_o, wr_o, rd_o, wdata_o} = '0;
  // One-cycle write strobe; released lines show the inverse so stale data cannot match.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
  endtask
  // Read data is taken a full cycle after the strobe edge, once it has settled.
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge clk_i);
    {addr_o, rd_o} = {a, 1'b1};
    @(negedge clk_i);
    {addr_o, rd_o} = {~a, 1'b0};
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule // hsch2_host_model

// [tb_hsch2_channel2_regs.sv]
// Self-checking testbench for the channel 2 register bank.
module tb_hsch2_channel2_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, srst_i = 1, wr, rd, sw_on = 0, sw_wr = 0, shut = 0, hyst = 0, comp = 0;
  logic scale = 1, clr = 0;
  logic [5:0] addr;
  logic [15:0] wdata, rdata, got, e;
  logic [2:0] done = 0;
  logic [9:0] dat [3] = '{10'h0, 10'h0, 10'h0};
  logic en, pd, pu, cmp, scl, ol, sh;
  logic [1:0] slew;
  int n_errors = 0, checks_done = 0;
  hsch2_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata));
  hsch2_channel2_regs #(.RETRY_TIME_US(1)) dut_u (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .switch_on_i(sw_on), .switch_state_write_i(sw_wr), .shutdown_evt_i(shut),
    .thermal_hysteresis_i(hyst), .fault_clear_i(clr), .offstate_comp_i(comp),
    .current_done_i(done[0]), .current_data_i(dat[0]), .current_scale_i(scale),
    .temperature_done_i(done[1]), .temperature_data_i(dat[1]), .voltage_done_i(done[2]),
    .voltage_data_i(dat[2]), .channel_enable_o(en), .pulldown_en_o(pd), .pullup_en_o(pu),
    .comparator_en_o(cmp), .slew_rate_select_o(slew), .sense_scale_select_o(scl),
    .offstate_openload_flag_o(ol), .short_to_supply_flag_o(sh));
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rdw(input logic [5:0] a, input logic [15:0] x);
    host_u.rd(a, got);
    chk("register read", x, got);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic results();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #(5000 * 50);
    n_errors++;
    results();
  end
  initial begin
    cyc(5);
    srst_i = 0;
    rdw(6'h19, 16'h4002);
    rdw(6'h1A, 16'hF000);
    rdw(6'h1B, 16'hF800);
    rdw(6'h1C, 16'hF800);
    rdw(6'h3F, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(6'h19, 16'h4000 | i[15:0]);
      rdw(6'h19, 16'h4000 | i[15:0]);
      chk("slew", i[15:0], {14'h0, slew});
    end
    host_u.wr(6'h19, 16'h0402);
    cyc(2);
    chk("scale", 16'h1, {15'h0, scl});
    // Each conversion is read once fresh, then written and read again stale.
    for (int i = 0; i < 3; i++) begin
      dat[i] = 10'h2A5 ^ i[9:0];
      done[i] = 1'b1;
      cyc(1);
      done[i] = 1'b0;
      e = (i == 0) ? {4'hF, 2'b11, dat[i]} : {5'h1F, 1'b1, dat[i]};
      rdw(6'h1A + i[5:0], e);
      host_u.wr(6'h1A + i[5:0], 16'hFFFF);
      rdw(6'h1A + i[5:0], e & 16'hFBFF);
    end
    // A later current conversion at 1x scaling must report the scale bit clear.
    scale = 1'b0;
    dat[0] = 10'h15A;
    done[0] = 1'b1;
    cyc(1);
    done[0] = 1'b0;
    rdw(6'h1A, {4'hF, 2'b01, 10'h15A});
    host_u.wr(6'h19, 16'h0012);
    comp = 1;
    cyc(8);
    chk("openload", 16'h1, {15'h0, ol});
    chk("pullup", 16'h1, {15'h0, pu});
    host_u.wr(6'h19, 16'h000A);
    cyc(8);
    chk("short", 16'h1, {15'h0, sh});
    chk("pulldown", 16'h1, {15'h0, pd});
    comp = 0;
    cyc(8);
    chk("short", 16'h0, {15'h0, sh});
    host_u.wr(6'h19, 16'h001A);
    cyc(4);
    chk("comparator", 16'h1, {15'h0, cmp});
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(1);
    chk("openload cleared", 16'h0, {15'h0, ol});
    host_u.wr(6'h19, 16'h0006);
    hyst = 1;
    sw_on = 1;
    sw_wr = 1;
    cyc(1);
    sw_wr = 0;
    cyc(3);
    chk("enable", 16'h1, {15'h0, en});
    shut = 1;
    cyc(1);
    shut = 0;
    cyc(30);
    chk("enable latched", 16'h0, {15'h0, en});
    sw_wr = 1;
    cyc(1);
    sw_wr = 0;
    cyc(3);
    chk("enable rewritten", 16'h1, {15'h0, en});
    host_u.wr(6'h19, 16'h0002);
    hyst = 1;
    shut = 1;
    cyc(1);
    shut = 0;
    cyc(5);
    chk("enable retry wait", 16'h0, {15'h0, en});
    cyc(30);
    chk("enable retried", 16'h1, {15'h0, en});
    hyst = 0;
    shut = 1;
    cyc(1);
    shut = 0;
    cyc(30);
    chk("enable no hysteresis", 16'h0, {15'h0, en});
    hyst = 1;
    cyc(4);
    chk("enable after hysteresis", 16'h1, {15'h0, en});
    results();
  end
endmodule // tb_hsch2_channel2_regs
